//--- bench/ccs_switcher_bench.sv
// Self-checking bench for the clock source switcher.
// Assumes the register port of ccs_switcher and ccs_consts.vh.
`timescale 1ns/1ps
`include "ccs_consts.vh"
`define CHK(n,e,g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module ccs_switcher_bench;
  reg ref_clk_in = 1'b0;
  reg rst_b_in = 1'b0;
  reg [1:0] addr_in = 2'h0;
  reg [7:0] wdata_in = 8'h00;
  reg wr_in = 1'b0;
  reg rd_in = 1'b0;
  reg [7:0] v;
  wire [7:0] rdata;
  wire hr, mr, lr, ar, sr, ms, as, ss;
  int error_cnt = 0;
  int check_count = 0;
  always #4 ref_clk_in = ~ref_clk_in;
  ccs_switcher DUT (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata), .high_osc_run_out(hr), .mid_osc_run_out(mr),
    .low_osc_run_out(lr), .main_osc_run_out(ar), .sub_osc_run_out(sr),
    .mid_osc_sel_out(ms), .main_sys_sel_out(as), .subsys_sel_out(ss));
  // --------------------------------------------------------------
  // Register port tasks
  // --------------------------------------------------------------
  task wr(input [1:0] a, input [7:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask
  task rd(input [1:0] a);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 v = rdata;
  endtask
  task chk_rd(input [1:0] a, input [7:0] e);
    rd(a);
    `CHK("register", e, v)
  endtask
  task wrap_up();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Bounded status poll; a stuck switch ends the run
  task poll(input [1:0] a, input int b);
    int n;
    n = 0;
    rd(a);
    while (v[b] !== 1'b1 && n < 40)
    begin
      rd(a);
      n++;
    end
    check_count++;
    if (n == 40)
    begin
      error_cnt++;
      $display("wrong value status poll exp 1 got 0");
      wrap_up();
    end
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    chk_rd(2'h0, `CCS_CSC_RESET);
    chk_rd(2'h1, `CCS_CKC_RESET);
    chk_rd(2'h2, `CCS_SEL_RESET);
    `CHK("high_run", 1'b1, hr)
    wr(2'h0, 8'hc2);
    chk_rd(2'h0, 8'hc2);
    `CHK("mid_run", 1'b1, mr)
    repeat (`CCS_MID_STAB_CYC) @(posedge ref_clk_in);
    wr(2'h1, 8'h01);
    chk_rd(2'h1, 8'h01);
    poll(2'h1, 1);
    `CHK("mid_sel", 1'b1, ms)
    wr(2'h2, 8'hff);
    chk_rd(2'h2, 8'h01);
    `CHK("low_run", 1'b1, lr)
    repeat (`CCS_LOW_STAB_CYC) @(posedge ref_clk_in);
    wr(2'h1, 8'h41);
    chk_rd(2'h1, 8'h43);
    poll(2'h1, 7);
    `CHK("subsys_sel", 1'b1, ss)
    wr(2'h0, 8'hc3);
    chk_rd(2'h0, 8'hc3);
    `CHK("high_run", 1'b0, hr)
    wr(2'h0, 8'h03);
    chk_rd(2'h0, 8'h03);
    `CHK("main_run", 1'b1, ar)
    `CHK("sub_run", 1'b1, sr)
    wr(2'h1, 8'hff);
    chk_rd(2'h1, 8'hd3);
    poll(2'h1, 5);
    `CHK("main_sys_sel", 1'b1, as)
    wr(2'h3, 8'hff);
    chk_rd(2'h3, 8'h00);
    chk_rd(2'h1, 8'hf3);
    wr(2'h0, 8'hc0);
    chk_rd(2'h0, 8'hc0);
    `CHK("main_run", 1'b0, ar)
    rst_b_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    chk_rd(2'h1, `CCS_CKC_RESET);
    wrap_up();
  end
endmodule // ccs_switcher_bench
bind ccs_switcher ccs_switcher_monitor u_mon (.ref_clk_in(ref_clk_in),
  .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .high_osc_run_out(high_osc_run_out), .mid_osc_run_out(mid_osc_run_out),
  .low_osc_run_out(low_osc_run_out), .main_osc_run_out(main_osc_run_out),
  .sub_osc_run_out(sub_osc_run_out), .mid_osc_sel_out(mid_osc_sel_out),
  .main_sys_sel_out(main_sys_sel_out), .subsys_sel_out(subsys_sel_out));

//--- bench/ccs_switcher_monitor.sv
// Checker for the clock source switcher port behaviour.
// Assumes it is bound onto ccs_switcher; one clock domain.
`timescale 1ns/1ps
module ccs_switcher_monitor (
  input wire ref_clk_in,
  input wire rst_b_in,
  input wire [1:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] rdata_out,
  input wire high_osc_run_out,
  input wire mid_osc_run_out,
  input wire low_osc_run_out,
  input wire main_osc_run_out,
  input wire sub_osc_run_out,
  input wire mid_osc_sel_out,
  input wire main_sys_sel_out,
  input wire subsys_sel_out
);
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  wire wc = wr_in && addr_in == 2'h0;
  wire wk = wr_in && addr_in == 2'h1;
  // Old source must stay until break-before-make has run its course
  sequence s_done(sig);
    !sig [*3] ##[1:6] sig;
  endsequence
  property p_switch(go, sig);
    go && !sig |=> s_done(sig);
  endproperty
  a_mid_osc_start: assert property (wc && wdata_in[1] |-> ##[1:2] mid_osc_run_out) else $error("mid osc not started");
  a_high_osc_stop: assert property (wc && wdata_in[0] |-> ##[1:2] !high_osc_run_out) else $error("high osc not stopped");
  a_mid_sel_switch: assert property (p_switch(wk && wdata_in[0], mid_osc_sel_out)) else $error("mid select timing");
  a_subsys_switch: assert property (p_switch(wk && wdata_in[6], subsys_sel_out)) else $error("subsystem select timing");
  a_main_sys_switch: assert property (p_switch(wk && wdata_in[4], main_sys_sel_out)) else $error("main system select timing");
  a_low_osc_start: assert property (wr_in && addr_in == 2'h2 && wdata_in[0] |-> ##[1:2] low_osc_run_out) else $error("low osc not started");
  a_main_osc_run: assert property (wc && !wdata_in[7] |-> ##[1:2] main_osc_run_out) else $error("main osc not started");
  a_sub_osc_run: assert property (wc && !wdata_in[6] |-> ##[1:2] sub_osc_run_out) else $error("sub osc not started");
  a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00) else $error("read data outside read slot");
endmodule // ccs_switcher_monitor

//--- verilog/ccs_consts.vh
// Constants of the CPU clock source switcher: register offsets, bit
// positions, reset values and timing counts.
// Assumes a 125 MHz register clock and 8-bit registers on a plain port.
//
// Notes on behaviour
// - Writing 1 to mid_osc_enable (status control bit 1) starts mid oscillator.
// - Writing 1 to mid_osc_select (system control bit 0) selects mid oscillator.
// - Device sets mid_osc_status (bit 1) when done; software checks before stop.
// - Writing 1 to high_osc_stop (status control bit 0) halts high oscillator.
// - low_osc_select bit 0 starts low oscillator as subsystem; bits 7..1 read 0.
// - Writing 1 to subsystem_select (bit 6) routes subsystem clock to cpu clock.
// - Device sets cpu_clock_source_status (bit 7) once cpu runs on subsystem.
// - Clearing main_osc_stop (bit 7) starts main oscillator; setting stops it.
// - Clearing sub_osc_stop (bit 6) starts the subsystem resonator oscillator.
// - main_system_clock_select (bit 4) picks external clock; status in bit 5.
`ifndef CCS_CONSTS_VH
`define CCS_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CCS_ADDR_CSC 2'h0
`define CCS_ADDR_CKC 2'h1
`define CCS_ADDR_SEL 2'h2

// ----------------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------------
`define CCS_HIGH_OSC_STOP 0
`define CCS_MID_OSC_ENABLE 1
`define CCS_SUB_OSC_STOP 6
`define CCS_MAIN_OSC_STOP 7
`define CCS_MID_OSC_SELECT 0
`define CCS_MID_OSC_STATUS 1
`define CCS_MAIN_SYS_SELECT 4
`define CCS_MAIN_SYS_STATUS 5
`define CCS_SUBSYS_SELECT 6
`define CCS_CPU_SRC_STATUS 7
`define CCS_LOW_OSC_SELECT 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CCS_CSC_RESET 8'hc0
`define CCS_CKC_RESET 8'h00
`define CCS_SEL_RESET 8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
// Cycles each mux stage waits on the old, then the new, clock phase
`define CCS_SYNC_STAGES 2
`define CCS_CLK_MHZ 125
`define CCS_MID_STAB_NS 4000
`define CCS_LOW_STAB_NS 210000
`define CCS_MID_STAB_CYC ((`CCS_MID_STAB_NS * `CCS_CLK_MHZ + 999) / 1000)
`define CCS_LOW_STAB_CYC ((`CCS_LOW_STAB_NS * `CCS_CLK_MHZ + 999) / 1000)

`endif

//--- verilog/ccs_glitch_mux.v
// Glitch-free two-way switch, modelled in the register clock domain.
// Assumes sel_in comes from logic on ref_clk_in.
`timescale 1ns/1ps
`include "ccs_consts.vh"
module ccs_glitch_mux #(
  parameter STAGES = `CCS_SYNC_STAGES
) (
  input wire ref_clk_in,
  input wire rst_b_in,
  input wire sel_in,
  output reg sel_out,
  output reg busy_out
);
  // ----------------------------------------------------------------------
  // Break-before-make sequence
  // ----------------------------------------------------------------------
  // Old source stays selected for 2*STAGES cycles before the new one is let
  // through, so no short pulse reaches the cpu clock.
  reg [3:0] cnt;
  always @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sel_out <= 1'b0;
      busy_out <= 1'b0;
      cnt <= 4'h0;
    end
    else if (sel_in != sel_out)
    begin
      busy_out <= 1'b1;
      if (cnt == 2 * STAGES - 1)
      begin
        sel_out <= sel_in;
        cnt <= 4'h0;
        busy_out <= 1'b0;
      end
      else
        cnt <= cnt + 4'h1;
    end
    else
    begin
      cnt <= 4'h0;
      busy_out <= 1'b0;
    end
  end
endmodule // ccs_glitch_mux

//--- verilog/ccs_switcher.v
// Clock source switcher: three control registers, oscillator enables and
// glitch-free source muxes with completion status.
// Assumes the register port master is on ref_clk_in; every output is registered
// on ref_clk_in, and there are no oscillator ready inputs.
`timescale 1ns/1ps
`include "ccs_consts.vh"
module ccs_switcher (
  input wire ref_clk_in,
  input wire rst_b_in,
  input wire [1:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  output reg high_osc_run_out,
  output reg mid_osc_run_out,
  output reg low_osc_run_out,
  output reg main_osc_run_out,
  output reg sub_osc_run_out,
  output reg mid_osc_sel_out,
  output reg main_sys_sel_out,
  output reg subsys_sel_out
);
  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  reg main_osc_stop;
  reg sub_osc_stop;
  reg mid_osc_enable;
  reg high_osc_stop;
  reg mid_osc_select;
  reg main_system_clock_select;
  reg subsystem_select;
  reg low_osc_select;
  wire wr_csc = wr_in && (addr_in == `CCS_ADDR_CSC);
  wire wr_ckc = wr_in && (addr_in == `CCS_ADDR_CKC);
  wire wr_sel = wr_in && (addr_in == `CCS_ADDR_SEL);

  always @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      main_osc_stop <= 1'b1;
      sub_osc_stop <= 1'b1;
      mid_osc_enable <= 1'b0;
      high_osc_stop <= 1'b0;
      mid_osc_select <= 1'b0;
      main_system_clock_select <= 1'b0;
      subsystem_select <= 1'b0;
      low_osc_select <= 1'b0;
    end
    else
    begin
      if (wr_csc)
      begin
        main_osc_stop <= wdata_in[`CCS_MAIN_OSC_STOP];
        sub_osc_stop <= wdata_in[`CCS_SUB_OSC_STOP];
        mid_osc_enable <= wdata_in[`CCS_MID_OSC_ENABLE];
        high_osc_stop <= wdata_in[`CCS_HIGH_OSC_STOP];
      end
      if (wr_ckc)
      begin
        mid_osc_select <= wdata_in[`CCS_MID_OSC_SELECT];
        main_system_clock_select <= wdata_in[`CCS_MAIN_SYS_SELECT];
        subsystem_select <= wdata_in[`CCS_SUBSYS_SELECT];
      end
      if (wr_sel)
        low_osc_select <= wdata_in[`CCS_LOW_OSC_SELECT];
    end
  end

  // ----------------------------------------------------------------------
  // Source muxes
  // ----------------------------------------------------------------------
  // Status comes from the mux outputs, never from the select bits, so
  // software sees completion only after the switch really happened.
  wire mid_done;
  wire main_done;
  wire sub_done;
  ccs_glitch_mux #(.STAGES(`CCS_SYNC_STAGES)) u_mid_mux (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .sel_in(mid_osc_select),
    .sel_out(mid_done),
    .busy_out()
  );
  ccs_glitch_mux #(.STAGES(`CCS_SYNC_STAGES)) u_main_mux (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .sel_in(main_system_clock_select),
    .sel_out(main_done),
    .busy_out()
  );
  ccs_glitch_mux #(.STAGES(`CCS_SYNC_STAGES)) u_sub_mux (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .sel_in(subsystem_select),
    .sel_out(sub_done),
    .busy_out()
  );

  // ----------------------------------------------------------------------
  // Read data and outputs
  // ----------------------------------------------------------------------
  reg [7:0] next_rdata;
  always @*
  begin
    next_rdata = 8'h00;
    if (rd_in)
    begin
      case (addr_in)
        `CCS_ADDR_CSC:
        begin
          next_rdata[`CCS_MAIN_OSC_STOP] = main_osc_stop;
          next_rdata[`CCS_SUB_OSC_STOP] = sub_osc_stop;
          next_rdata[`CCS_MID_OSC_ENABLE] = mid_osc_enable;
          next_rdata[`CCS_HIGH_OSC_STOP] = high_osc_stop;
        end
        `CCS_ADDR_CKC:
        begin
          next_rdata[`CCS_CPU_SRC_STATUS] = sub_done;
          next_rdata[`CCS_SUBSYS_SELECT] = subsystem_select;
          next_rdata[`CCS_MAIN_SYS_STATUS] = main_done;
          next_rdata[`CCS_MAIN_SYS_SELECT] = main_system_clock_select;
          next_rdata[`CCS_MID_OSC_STATUS] = mid_done;
          next_rdata[`CCS_MID_OSC_SELECT] = mid_osc_select;
        end
        `CCS_ADDR_SEL:
          next_rdata[`CCS_LOW_OSC_SELECT] = low_osc_select;
        default:
          next_rdata = 8'h00;
      endcase
    end
  end

  always @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rdata_out <= 8'h00;
      high_osc_run_out <= 1'b1;
      mid_osc_run_out <= 1'b0;
      low_osc_run_out <= 1'b0;
      main_osc_run_out <= 1'b0;
      sub_osc_run_out <= 1'b0;
      mid_osc_sel_out <= 1'b0;
      main_sys_sel_out <= 1'b0;
      subsys_sel_out <= 1'b0;
    end
    else
    begin
      rdata_out <= next_rdata;
      high_osc_run_out <= ~high_osc_stop;
      mid_osc_run_out <= mid_osc_enable;
      low_osc_run_out <= low_osc_select;
      main_osc_run_out <= ~main_osc_stop;
      sub_osc_run_out <= ~sub_osc_stop;
      mid_osc_sel_out <= mid_done;
      main_sys_sel_out <= main_done;
      subsys_sel_out <= sub_done;
    end
  end
endmodule // ccs_switcher
